// file: logic/cfh_frame_engine.sv
// CAN frame, error frame and fault confinement engine
`timescale 1ns/100ps
`include "cfh_defs.svh"

module cfh_frame_engine
  import cfh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_wake,
  input wire logic i_bit_tick,
  input wire logic i_rx,
  output logic o_tx,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire cfh_frame_t i_tx_frame,
  output logic o_tx_done,
  output logic o_rx_valid,
  output cfh_frame_t o_rx_frame,
  output cfh_err_t o_err,
  output cfh_fc_t o_fc_state,
  output logic [7:0] o_tec,
  output logic [7:0] o_rec
);

  localparam cfh_state_t ST_RST = '{mode: M_SYNC, tx: 1'b1, default: '0};

  cfh_state_t q;
  cfh_state_t d;
  cfh_frame_t fifo_data;
  logic fifo_valid;
  logic pop;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
    logic [14:0] s;
    s = {c[13:0], 1'b0};
    if (b ^ c[14])
    begin
      s = s ^ `CFH_CRC_POLY;
    end
    return s;
  endfunction : crc_step

  // First position after the data field; a remote frame has none
  function automatic logic [6:0] data_end(input cfh_frame_t f);
    logic [3:0] n;
    n = (f.dlc > `CFH_MAX_BYTES) ? `CFH_MAX_BYTES : f.dlc;
    if (f.rtr)
    begin
      n = 4'h0;
    end
    return `CFH_HDR_BITS + {n, 3'b000};
  endfunction : data_end

  // Destuffed transmit level at a position before the CRC
  function automatic logic tx_bit(input cfh_frame_t f, input logic [6:0] p);
    logic r;
    r = 1'b0;
    if (p == 7'h00)
    begin
      r = 1'b0;
    end
    else if (p <= `CFH_ID_LAST)
    begin
      r = f.id[4'(`CFH_ID_LAST - p)];
    end
    else if (p == `CFH_ARB_LAST)
    begin
      r = f.rtr;
    end
    else if (p > `CFH_DLC_LAST)
    begin
      r = f.data[6'(`CFH_HDR_BITS + `CFH_DATA_TOP - p)];
    end
    else if (p > `CFH_DLC_LAST - 7'h04)
    begin
      r = f.dlc[2'(`CFH_DLC_LAST - p)];
    end
    return r;
  endfunction : tx_bit

  function automatic cfh_fc_t fc_of(input logic [8:0] tec, input logic [7:0] rec);
    cfh_fc_t s;
    if (tec >= `CFH_BO_LIM)
    begin
      s = FC_BUSOFF;
    end
    else if (tec >= `CFH_PASS_LIM || {1'b0, rec} >= `CFH_PASS_LIM)
    begin
      s = FC_PASSIVE;
    end
    else if (tec >= `CFH_WARN_LIM || {1'b0, rec} >= `CFH_WARN_LIM)
    begin
      s = FC_WARN;
    end
    else
    begin
      s = FC_ACTIVE;
    end
    return s;
  endfunction : fc_of

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  assign pop = i_bit_tick && i_enable && !i_wake && i_rx && q.mode == M_IDLE && !q.tx_pend;

  cfh_fifo #(
    .WIDTH($bits(cfh_frame_t)),
    .DEPTH(`CFH_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_tx_valid),
    .o_ready(o_tx_ready),
    .i_data(i_tx_frame),
    .o_valid(fifo_valid),
    .i_ready(pop),
    .o_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  always_comb
  begin
    logic b;
    logic sof;
    logic ovl;
    cfh_err_t e;
    cfh_fc_t fc;
    logic [6:0] cend;
    b = i_rx;
    sof = 1'b0;
    ovl = 1'b0;
    e = '0;
    fc = fc_of(q.tec, q.rec);
    cend = data_end(q.rxf) + `CFH_CRC_BITS - 7'h01;
    d = q;
    d.rx_valid = 1'b0;
    d.tx_done = 1'b0;
    d.err = '0;
    if (!i_enable || i_wake)
    begin
      d.mode = M_SYNC;
      d.cnt = 4'h0;
      d.tx = 1'b1;
      d.txing = 1'b0;
      if (!i_enable)
      begin
        d.tec = '0;
        d.rec = '0;
        d.tx_pend = 1'b0;
      end
    end
    else if (i_bit_tick)
    begin
      case (q.mode)
        M_SYNC, M_SKIP:
        begin
          d.cnt = b ? q.cnt + 4'h1 : 4'h0;
          if (b && q.cnt == `CFH_IDLE_RUN - 4'h1)
          begin
            d.mode = M_IDLE;
            d.cnt = 4'h0;
          end
        end
        M_IDLE:
        begin
          if (!b)
          begin
            sof = 1'b1;
          end
          else if (q.tx_pend || fifo_valid)
          begin
            if (!q.tx_pend)
            begin
              d.txf = fifo_data;
              d.tx_pend = 1'b1;
            end
            d.tx = 1'b0;
          end
        end
        M_FRAME:
        begin
          if (q.run == `CFH_STUFF_RUN)
          begin
            if (b == q.last)
            begin
              e.stuff = 1'b1;
            end
            else
            begin
              d.last = b;
              d.run = 3'h1;
              if (q.pos > cend)
              begin
                d.mode = M_TAIL;
                d.cnt = 4'h0;
              end
            end
          end
          else
          begin
            if (q.txing && b != q.tx)
            begin
              if (q.tx && q.pos <= `CFH_ARB_LAST)
              begin
                d.txing = 1'b0;
              end
              else
              begin
                e.bit_e = 1'b1;
              end
            end
            d.run = (b == q.last) ? q.run + 3'h1 : 3'h1;
            d.last = b;
            d.crc = crc_step(q.crc, b);
            if (q.pos <= `CFH_ID_LAST)
            begin
              d.rxf.id[4'(`CFH_ID_LAST - q.pos)] = b;
            end
            else if (q.pos == `CFH_ARB_LAST)
            begin
              d.rxf.rtr = b;
            end
            else if (q.pos == `CFH_IDE_POS && b)
            begin
              d.mode = M_SKIP;
              d.cnt = 4'h0;
            end
            else if (q.pos > `CFH_DLC_LAST)
            begin
              if (q.pos < data_end(q.rxf))
              begin
                d.rxf.data[6'(`CFH_HDR_BITS + `CFH_DATA_TOP - q.pos)] = b;
              end
            end
            else if (q.pos > `CFH_DLC_LAST - 7'h04)
            begin
              d.rxf.dlc[2'(`CFH_DLC_LAST - q.pos)] = b;
            end
            d.pos = q.pos + 7'h01;
            if (q.pos == cend && d.run != `CFH_STUFF_RUN)
            begin
              d.mode = M_TAIL;
              d.cnt = 4'h0;
            end
          end
          if (d.mode == M_FRAME && d.txing)
          begin
            if (d.run == `CFH_STUFF_RUN)
            begin
              d.tx = !d.last;
            end
            else if (d.pos < data_end(d.rxf))
            begin
              d.tx = tx_bit(q.txf, d.pos);
            end
            else
            begin
              d.tx = d.crc[14];
            end
          end
          else
          begin
            d.tx = 1'b1;
          end
        end
        M_TAIL:
        begin
          d.cnt = q.cnt + 4'h1;
          d.tx = 1'b1;
          if (q.txing && q.cnt != `CFH_ACK_SLOT && b != q.tx)
          begin
            e.bit_e = 1'b1;
          end
          if (q.cnt == `CFH_CRC_DELIM)
          begin
            e.form = !b;
            d.crc_bad = !q.txing && q.crc != 15'h0000;
            d.tx = q.txing || q.crc != 15'h0000;
          end
          else if (q.cnt == `CFH_ACK_SLOT)
          begin
            e.ack = q.txing && b;
          end
          else if (q.cnt == `CFH_ACK_DELIM)
          begin
            e.form = !b;
            e.crc = b && q.crc_bad;
          end
          else if (q.cnt == `CFH_ACK_DELIM + `CFH_EOF_BITS)
          begin
            e.form = !b && q.txing;
            if (q.txing)
            begin
              d.tx_done = 1'b1;
              d.tx_pend = 1'b0;
              d.tec = (q.tec != 9'h000) ? q.tec - 9'h001 : q.tec;
            end
            else
            begin
              d.rx_valid = 1'b1;
              d.rxo = q.rxf;
              d.rec = (q.rec != 8'h00) ? q.rec - 8'h01 : q.rec;
            end
            d.was_tx = q.txing;
            d.txing = 1'b0;
            d.mode = M_INTER;
            d.cnt = 4'h0;
            ovl = !b && !q.txing;
          end
          else
          begin
            e.form = !b;
          end
        end
        M_INTER:
        begin
          d.cnt = q.cnt + 4'h1;
          if (!b)
          begin
            ovl = q.cnt < `CFH_INTER_BITS - 4'h1;
            sof = !ovl;
          end
          else if (q.cnt == `CFH_INTER_BITS - 4'h1)
          begin
            d.mode = (fc == FC_PASSIVE && q.was_tx) ? M_SUSP : M_IDLE;
            d.cnt = 4'h0;
          end
        end
        M_SUSP:
        begin
          d.cnt = q.cnt + 4'h1;
          sof = !b;
          if (b && q.cnt == `CFH_SUSP_BITS - 4'h1)
          begin
            d.mode = M_IDLE;
          end
        end
        M_EFLAG:
        begin
          if (q.flag_dom && !q.is_ovl && b)
          begin
            if (q.was_tx)
            begin
              d.tec = q.tec + `CFH_TX_INC;
            end
            else if (!q.rec[7])
            begin
              d.rec = q.rec + `CFH_RX_BIG_INC;
            end
          end
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == `CFH_FLAG_BITS - 4'h1)
          begin
            d.mode = M_EWAIT;
            d.tx = 1'b1;
          end
        end
        M_EWAIT:
        begin
          if (b)
          begin
            d.mode = M_EDELIM;
            d.cnt = 4'h1;
          end
        end
        M_EDELIM:
        begin
          e.form = !b;
          d.cnt = q.cnt + 4'h1;
          if (b && q.cnt == `CFH_DELIM_BITS - 4'h1)
          begin
            d.mode = M_INTER;
            d.cnt = 4'h0;
          end
        end
        M_BUSOFF:
        begin
          d.tx = 1'b1;
          d.cnt = b ? q.cnt + 4'h1 : 4'h0;
          if (b && q.cnt == `CFH_IDLE_RUN - 4'h1)
          begin
            d.cnt = 4'h0;
            d.grp = q.grp + 8'h01;
            if (q.grp == `CFH_BO_GROUPS - 8'h01)
            begin
              d.mode = M_IDLE;
              d.tec = '0;
              d.rec = '0;
            end
          end
        end
        default:
        begin
          d.mode = M_SYNC;
        end
      endcase
      if (sof)
      begin
        d.mode = M_FRAME;
        d.pos = 7'h01;
        d.run = 3'h1;
        d.last = 1'b0;
        d.crc = '0;
        d.rxf = '0;
        d.crc_bad = 1'b0;
        d.txing = !q.tx && q.tx_pend;
        d.tx = d.txing ? tx_bit(q.txf, 7'h01) : 1'b1;
      end
      if (ovl)
      begin
        d.mode = M_EFLAG;
        d.cnt = 4'h0;
        d.is_ovl = 1'b1;
        d.flag_dom = 1'b1;
        d.tx = 1'b0;
      end
      if (|e)
      begin
        d.err = e;
        d.mode = M_EFLAG;
        d.cnt = 4'h0;
        d.is_ovl = 1'b0;
        d.was_tx = q.txing;
        d.txing = 1'b0;
        d.flag_dom = fc == FC_ACTIVE || fc == FC_WARN;
        d.tx = !d.flag_dom;
        if (q.txing)
        begin
          if (!((e.ack && fc == FC_PASSIVE) || (e.stuff && q.pos <= `CFH_ARB_LAST)))
          begin
            d.tec = q.tec + `CFH_TX_INC;
          end
        end
        else if (!q.rec[7])
        begin
          d.rec = q.rec + `CFH_RX_INC;
        end
      end
      if (d.tec >= `CFH_BO_LIM && q.mode != M_BUSOFF)
      begin
        d.mode = M_BUSOFF;
        d.cnt = 4'h0;
        d.grp = 8'h00;
        d.tx = 1'b1;
        d.txing = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= ST_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_tx = q.tx;
  assign o_tx_done = q.tx_done;
  assign o_rx_valid = q.rx_valid;
  assign o_rx_frame = q.rxo;
  assign o_err = q.err;
  assign o_fc_state = (q.mode == M_SYNC) ? FC_SYNC : fc_of(q.tec, q.rec);
  assign o_tec = q.tec[8] ? 8'hFF : q.tec[7:0];
  assign o_rec = q.rec;

endmodule : cfh_frame_engine

// file: logic/cfh_defs.svh
// Constants of the CAN frame and error handler
`ifndef CFH_DEFS_SVH
`define CFH_DEFS_SVH

// ----------------------------------------------------------------
// Bit counts on the bus
// ----------------------------------------------------------------
`define CFH_IDLE_RUN 4'hB
`define CFH_FLAG_BITS 4'h6
`define CFH_DELIM_BITS 4'h8
`define CFH_EOF_BITS 4'h7
`define CFH_INTER_BITS 4'h3
`define CFH_SUSP_BITS 4'h8
`define CFH_STUFF_RUN 3'h5
`define CFH_BO_GROUPS 8'h80

// ----------------------------------------------------------------
// Positions in the destuffed frame, SOF at zero
// ----------------------------------------------------------------
`define CFH_ID_LAST 7'h0B
`define CFH_ARB_LAST 7'h0C
`define CFH_IDE_POS 7'h0D
`define CFH_DLC_LAST 7'h12
`define CFH_HDR_BITS 7'h13
`define CFH_DATA_TOP 7'h3F
`define CFH_CRC_BITS 7'h0F
`define CFH_MAX_BYTES 4'h8
`define CFH_CRC_POLY 15'h4599

// ----------------------------------------------------------------
// Positions after the CRC sequence
// ----------------------------------------------------------------
`define CFH_CRC_DELIM 4'h0
`define CFH_ACK_SLOT 4'h1
`define CFH_ACK_DELIM 4'h2

// ----------------------------------------------------------------
// Error counter limits and steps
// ----------------------------------------------------------------
`define CFH_WARN_LIM 9'h060
`define CFH_PASS_LIM 9'h080
`define CFH_BO_LIM 9'h100
`define CFH_TX_INC 9'h008
`define CFH_RX_INC 8'h01
`define CFH_RX_BIG_INC 8'h08

// ----------------------------------------------------------------
// Transmit queue
// ----------------------------------------------------------------
`define CFH_FIFO_DEPTH 4

`endif

// file: logic/cfh_pkg.sv
// Types of the CAN frame and error handler
package cfh_pkg;

  typedef struct packed {
    logic [10:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } cfh_frame_t;

  typedef struct packed {
    logic bit_e;
    logic stuff;
    logic form;
    logic crc;
    logic ack;
  } cfh_err_t;

  typedef enum logic [2:0] {
    FC_SYNC,
    FC_ACTIVE,
    FC_WARN,
    FC_PASSIVE,
    FC_BUSOFF
  } cfh_fc_t;

  typedef enum logic [3:0] {
    M_SYNC,
    M_IDLE,
    M_FRAME,
    M_TAIL,
    M_INTER,
    M_SUSP,
    M_EFLAG,
    M_EWAIT,
    M_EDELIM,
    M_SKIP,
    M_BUSOFF
  } cfh_mode_t;

  typedef struct packed {
    cfh_mode_t mode;
    logic tx;
    logic txing;
    logic tx_pend;
    logic was_tx;
    logic flag_dom;
    logic is_ovl;
    logic crc_bad;
    logic last;
    logic [2:0] run;
    logic [6:0] pos;
    logic [3:0] cnt;
    logic [7:0] grp;
    logic [14:0] crc;
    logic [8:0] tec;
    logic [7:0] rec;
    cfh_frame_t txf;
    cfh_frame_t rxf;
    cfh_frame_t rxo;
    logic rx_valid;
    logic tx_done;
    cfh_err_t err;
  } cfh_state_t;

endpackage : cfh_pkg

// file: logic/cfh_fifo.sv
// Transmit frame queue with valid and ready on both sides
`timescale 1ns/100ps

module cfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cfh_fifo_state_t;

  cfh_fifo_state_t q;
  cfh_fifo_state_t d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign o_ready = q.cnt != (AW + 1)'(DEPTH);
  assign o_valid = q.cnt != '0;
  assign o_data = q.mem[q.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = i_data;
      d.wp = bump(q.wp);
    end
    if (pop)
    begin
      d.rp = bump(q.rp);
    end
    if (push && !pop)
    begin
      d.cnt = q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : cfh_fifo

// file: bench/cfh_frame_engine_sva.sv
// Assertions on the CAN frame engine ports
`timescale 1ns/100ps

module cfh_fe_sva
  import cfh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_wake,
  input wire logic i_bit_tick,
  input wire logic i_rx,
  input wire logic o_tx,
  input wire cfh_err_t o_err,
  input wire cfh_fc_t o_fc_state,
  input wire logic [7:0] o_tec,
  input wire logic [7:0] o_rec
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [3:0] run_q;
  logic [2:0] fl_q;
  logic act;
  assign act = o_fc_state == FC_ACTIVE || o_fc_state == FC_WARN;
  // ----------------------------------------------------------------
  // Recessive run in sync, bits into an active ack error flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_enable || i_wake || o_fc_state != FC_SYNC || (i_bit_tick && !i_rx))
      run_q <= 4'h0;
    else if (i_bit_tick)
      run_q <= run_q + 4'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst || fl_q == 3'h7)
      fl_q <= 3'h0;
    else if (o_err.ack && !o_tx)
      fl_q <= 3'h1;
    else if (fl_q != 3'h0 && i_bit_tick)
      fl_q <= fl_q + 3'h1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sync_wait_a: assert property (o_fc_state == FC_SYNC && run_q < 4'hA |=> o_fc_state == FC_SYNC)
    else $error("sync left early");
  sync_exit_a: assert property (o_fc_state == FC_SYNC && run_q == 4'hA && i_bit_tick && i_rx
    && i_enable && !i_wake |=> o_fc_state != FC_SYNC)
    else $error("sync not left");
  wake_sync_a: assert property (i_wake && i_enable |=> o_fc_state == FC_SYNC && $stable(o_tec))
    else $error("wake handling wrong");
  off_clear_a: assert property (!i_enable |=> o_fc_state == FC_SYNC && o_tec == 8'h00
    && o_rec == 8'h00)
    else $error("disable did not clear");
  warn_lvl_a: assert property (act |-> (o_fc_state == FC_WARN) == (o_tec >= 8'h60 || o_rec >= 8'h60))
    else $error("warning state wrong");
  pass_lvl_a: assert property (act || o_fc_state == FC_PASSIVE |->
    (o_fc_state == FC_PASSIVE) == (o_tec[7] || o_rec[7]))
    else $error("passive state wrong");
  flag_dom_a: assert property ((|o_err) && $past(act) |-> !o_tx)
    else $error("active flag not dominant");
  flag_rec_a: assert property ((|o_err) && $past(o_fc_state) == FC_PASSIVE |-> o_tx)
    else $error("passive flag not recessive");
  flag_len_a: assert property (fl_q != 3'h0 && fl_q != 3'h7 |-> !o_tx)
    else $error("flag too short");
  flag_end_a: assert property (fl_q == 3'h7 |-> o_tx)
    else $error("flag too long");
  tec_step_a: assert property (o_err.ack && $past(act) |-> o_tec == $past(o_tec) + 8'h08)
    else $error("tec step wrong");
endmodule : cfh_fe_sva

bind cfh_frame_engine cfh_fe_sva u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable), .i_wake(i_wake),
  .i_bit_tick(i_bit_tick), .i_rx(i_rx), .o_tx(o_tx), .o_err(o_err),
  .o_fc_state(o_fc_state), .o_tec(o_tec), .o_rec(o_rec)
);

// file: bench/cfh_bus_node.sv
// Receiving CAN node that acknowledges frames
`timescale 1ns/100ps

module cfh_bus_node (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_bus,
  input wire logic i_ack_en,
  output logic o_tx,
  output logic [10:0] o_id,
  output logic o_rtr
);
  logic busy, lst;
  logic [2:0] run;
  logic [3:0] idl;
  logic [6:0] cnt, tot;
  logic [17:0] sh;
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      busy = 1'b0;
      idl = 4'h0;
      o_tx <= 1'b1;
    end
    else if (i_tick)
    begin
      o_tx <= 1'b1;
      if (!busy)
      begin
        if (!i_bus && idl >= 4'hB)
        begin
          busy = 1'b1;
          cnt = 7'h01;
          run = 3'h1;
          lst = 1'b0;
          tot = 7'h7F;
        end
        idl = i_bus ? idl + {3'h0, idl != 4'hF} : 4'h0;
      end
      else if (run == 3'h5)
      begin
        // Stuff bit dropped
        run = (cnt < tot) ? 3'h1 : 3'h0;
        lst = i_bus;
      end
      else if (cnt < tot)
      begin
        run = (i_bus == lst) ? run + 3'h1 : 3'h1;
        lst = i_bus;
        sh = {sh[16:0], i_bus};
        cnt = cnt + 7'h01;
        if (cnt == 7'h13)
        begin
          o_id <= sh[17:7];
          o_rtr <= sh[6];
          tot = 7'h22 + (sh[6] ? 7'h00 : (sh[3] ? 7'h40 : {1'b0, sh[2:0], 3'h0}));
        end
      end
      else
      begin
        // CRC delimiter seen, acknowledge next bit
        o_tx <= !i_ack_en;
        busy = 1'b0;
        idl = 4'h0;
      end
    end
  end
endmodule : cfh_bus_node

// file: bench/cfh_frame_engine_tb.sv
// Testbench of the CAN frame engine
`timescale 1ns/100ps

module cfh_frame_engine_tb;
  import cfh_pkg::*;
  logic clk, rst, en, wake, tx_valid, ack_en, tx, node_tx, tx_ready, tx_done, rx_valid;
  logic tick = 1'b0;
  logic tick_on = 1'b1;
  logic tb_drv = 1'b0;
  logic [1:0] tc = 2'h0;
  cfh_frame_t tx_frame, rx_frame;
  cfh_err_t err;
  cfh_fc_t fc;
  logic [7:0] tec, rec;
  logic [10:0] node_id;
  logic node_rtr;
  int miscompares, checked;
  cfh_frame_t tab [4];
  wire rx = tx & node_tx & tb_drv;

  cfh_frame_engine DUT (.i_clk(clk), .i_rst(rst), .i_enable(en), .i_wake(wake),
    .i_bit_tick(tick), .i_rx(rx), .o_tx(tx), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_tx_frame(tx_frame), .o_tx_done(tx_done), .o_rx_valid(rx_valid), .o_rx_frame(rx_frame),
    .o_err(err), .o_fc_state(fc), .o_tec(tec), .o_rec(rec));
  cfh_bus_node u_node (.i_clk(clk), .i_rst(rst), .i_tick(tick), .i_bus(rx),
    .i_ack_en(ack_en), .o_tx(node_tx), .o_id(node_id), .o_rtr(node_rtr));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bit strobe every fourth cycle
  // ----------------------------------------------------------------
  always @(negedge clk)
  begin
    tc <= tc + 2'h1;
    tick <= tick_on && tc == 2'h3;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : check
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge clk);
      while (tick !== 1'b1) @(posedge clk);
      @(negedge clk);
    end
  endtask : tk
  task automatic wait_ev(input logic want_err);
    int i;
    tk(1);
    i = 1;
    while ((want_err ? |err : tx_done) !== 1'b1 && i < 400)
    begin
      tk(1);
      i++;
    end
    check("event", want_err ? |err : tx_done, 1'b1);
  endtask : wait_ev
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sync;
    tk(2);
    tb_drv = 1'b1;
    tk(10);
    check("sync", fc, FC_SYNC);
    tk(1);
    check("active", fc, FC_ACTIVE);
  endtask : t_sync
  task automatic t_ovl;
    tb_drv = 1'b0;
    tk(1);
    tb_drv = 1'b1;
    check("ovl_err", err, 5'h00);
    repeat (6)
    begin
      check("ovl_flag", tx, 1'b0);
      tk(1);
    end
    check("ovl_delim", tx, 1'b1);
    tk(12);
  endtask : t_ovl
  task automatic t_queue;
    tab[0] = '{11'h123, 1'b0, 4'h2, 64'hABCD_0000_0000_0000};
    tab[1] = '{11'h456, 1'b1, 4'h4, 64'h0000_0000_0000_0000};
    tab[2] = '{11'h7A5, 1'b0, 4'h8, 64'h0123_4567_89AB_CDEF};
    tab[3] = '{11'h001, 1'b0, 4'h0, 64'h0000_0000_0000_0000};
    tick_on = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      if (k == 3)
        check("ready", tx_ready, 1'b1);
      tx_valid = 1'b1;
      tx_frame = tab[k % 4];
      @(negedge clk);
    end
    tx_valid = 1'b0;
    check("full", tx_ready, 1'b0);
    tick_on = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wait_ev(1'b0);
      check("id", node_id, tab[k].id);
      check("rtr", node_rtr, tab[k].rtr);
      if (k < 3)
      begin
        repeat (2)
        begin
          check("space", tx, 1'b1);
          tk(1);
        end
        check("space", tx, 1'b1);
      end
    end
    t_ovl;
    check("tec0", tec, 8'h00);
  endtask : t_queue
  task automatic t_noack;
    logic [7:0] e;
    e = 8'h00;
    ack_en = 1'b0;
    tx_valid = 1'b1;
    tx_frame = tab[0];
    @(negedge clk);
    tx_valid = 1'b0;
    repeat (18)
    begin
      wait_ev(1'b1);
      check("err", err, 5'h01);
      check("flag", tx, e > 8'h7F);
      if (e < 8'h80)
        e = e + 8'h08;
      check("tec", tec, e);
      check("state", fc, e > 8'h7F ? FC_PASSIVE : e > 8'h5F ? FC_WARN : FC_ACTIVE);
    end
    ack_en = 1'b1;
    wait_ev(1'b0);
    check("tec", tec, 8'h7F);
    check("back", fc, FC_WARN);
  endtask : t_noack
  task automatic t_wake_off;
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    check("wake", {fc, tec}, {FC_SYNC, 8'h7F});
    tk(11);
    check("rejoin", fc, FC_WARN);
    en = 1'b0;
    @(negedge clk);
    en = 1'b1;
    check("off", {fc, tec}, {FC_SYNC, 8'h00});
    tk(11);
    check("on", fc, FC_ACTIVE);
  endtask : t_wake_off
  task automatic t_rx;
    logic [33:0] f;
    logic [14:0] c;
    logic l;
    int n;
    f = {1'b0, 11'h2B4, 1'b1, 2'h0, 4'h3, 15'h0000};
    c = 15'h0000;
    l = 1'b1;
    n = 0;
    for (int k = 33; k > 14; k--)
      c = {c[13:0], 1'b0} ^ ((f[k] ^ c[14]) ? 15'h4599 : 15'h0000);
    f[14:0] = c;
    for (int k = 34; k >= 0; k--)
    begin
      if (n == 5)
      begin
        l = !l;
        tb_drv = l;
        n = 1;
        tk(1);
      end
      if (k > 0)
      begin
        n = (f[k-1] == l) ? n + 1 : 1;
        l = f[k-1];
        tb_drv = l;
        tk(1);
      end
    end
    tb_drv = 1'b1;
    tk(1);
    check("rx_ack", tx, 1'b0);
    tk(9);
    check("rx_valid", rx_valid, 1'b1);
    check("rx_id", rx_frame.id, 11'h2B4);
    check("rx_ctl", {rx_frame.rtr, rx_frame.dlc}, 5'h13);
    check("rx_err", err, 5'h00);
    check("rx_rec", rec, 8'h00);
  endtask : t_rx
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    checked = 0;
    rst = 1'b1;
    en = 1'b1;
    wake = 1'b0;
    ack_en = 1'b1;
    tx_valid = 1'b0;
    tx_frame = '0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_sync;
    t_queue;
    t_noack;
    t_wake_off;
    t_rx;
    stop_test;
  end
  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    stop_test;
  end
endmodule : cfh_frame_engine_tb
